//--- logic/fci_unit.sv
//----------------------------------------------------------------------------
// Compare-unordered and float-to-integer conversion unit with its status register.
// Assumes operands arrive with the instruction and results are taken one cycle later.
//----------------------------------------------------------------------------
`timescale 1ns/1ps
module fci_unit #(
    parameter bit IMPL_64 = 1'b1                   // 64-bit implementation
) (
    // Clock and reset
    input  wire logic                i_sys_clk,
    input  wire logic                i_rst_b,
    // Issue and operands
    input  wire fci_pkg::fci_issue_t i_issue,
    // Results
    output      fci_pkg::fci_wb_t    o_wb,
    output      fci_pkg::fci_cr_t    o_cr,
    output      logic                o_illegal,
    // Register port
    input  wire fci_pkg::fci_bus_t   i_bus,
    output      logic [31:0]         o_rdata,
    // Interrupt
    output      logic                o_irq
);
    import fci_pkg::*;

    //************************************************
    // Helper functions
    //************************************************
    function automatic fci_op_t f_decode(input logic [31:0] ins);
        fci_op_t op;
        op = OP_ILLEGAL;
        if (ins[31:26] == PRIM_OPC) begin
            unique case (ins[10:1])
                XO_CMPU:   op = OP_CMPU;
                XO_CVT_D:  op = IMPL_64 ? OP_CVT_D  : OP_ILLEGAL;  // see [RULE_10]
                XO_CVT_DZ: op = IMPL_64 ? OP_CVT_DZ : OP_ILLEGAL;  // see [RULE_10]
                XO_CVT_W:  op = OP_CVT_W;
                XO_CVT_WZ: op = OP_CVT_WZ;
                default:   op = OP_ILLEGAL;
            endcase
        end
        return op;
    endfunction : f_decode

    function automatic logic f_is_nan(input logic [63:0] x);
        return (x[62:52] == EXP_MAX) && (x[51:0] != 52'h0);
    endfunction : f_is_nan

    function automatic logic f_is_snan(input logic [63:0] x);
        return f_is_nan(x) && !x[51];
    endfunction : f_is_snan

    // Orders two doubles; zeros of either sign compare equal
    function automatic logic [3:0] f_compare(input logic [63:0] a, input logic [63:0] b);
        logic [63:0] ka;
        logic [63:0] kb;
        logic [3:0]  cc;
        ka = a[63] ? ~a : {1'b1, a[62:0]};
        kb = b[63] ? ~b : {1'b1, b[62:0]};
        if (f_is_nan(a) || f_is_nan(b))                 cc = CC_UN;  // see [RULE_03]
        else if ((a[62:0] | b[62:0]) == 63'h0)          cc = CC_EQ;
        else if (ka < kb)                               cc = CC_LT;
        else if (ka > kb)                               cc = CC_GT;
        else                                            cc = CC_EQ;
        return cc;
    endfunction : f_compare

    // Converts a double to a signed integer of 64 or 32 bits with saturation
    function automatic fci_cvt_t f_convert(input logic [63:0] op, input logic [1:0] rn,
                                           input logic is32);
        logic        sgn;
        logic [10:0] ex;
        logic [51:0] fr;
        logic [127:0] t;
        logic        g;
        logic        st;
        logic        inc;
        logic        big;
        logic        nan;
        logic        exact_min;
        logic [64:0] mag;
        logic [64:0] lim;
        logic [63:0] sat;
        logic [63:0] sval;
        fci_cvt_t    r;
        sgn = op[63];
        ex  = op[62:52];
        fr  = op[51:0];
        t   = 128'h0;
        st  = 1'b0;
        big = ex >= EXP_BIG;
        nan = f_is_nan(op);
        exact_min = sgn && (ex == EXP_BIG) && (fr == 52'h0) && !is32;
        if (ex >= EXP_HALF && !big) begin
            t = 128'({1'b1, fr}) << (ex - EXP_SHIFT);
        end else begin
            st = (ex != 11'h0) || (fr != 52'h0);
        end
        g  = t[63];
        st = st | (|t[62:0]);
        unique case (rn)
            RN_NEAR: inc = g & (st | t[64]);
            RN_ZERO: inc = 1'b0;
            RN_PINF: inc = !sgn & (g | st);
            RN_MINF: inc = sgn & (g | st);
        endcase
        mag = {1'b0, t[127:64]} + {64'h0, inc};
        if (is32) lim = sgn ? LIM_W_NEG : LIM_W_POS;
        else      lim = sgn ? LIM_D_NEG : LIM_D_POS;
        r.inv  = nan | (big & !exact_min) | (!big & (mag > lim));  // see [RULE_16]
        r.snan = f_is_snan(op);
        if (is32) sat = {32'h0, (sgn || nan) ? SAT_W_NEG : SAT_W_POS};  // see [RULE_14]
        else      sat = (sgn || nan) ? SAT_D_NEG : SAT_D_POS;          // see [RULE_08]
        sval  = sgn ? (64'h0 - mag[63:0]) : mag[63:0];
        if (r.inv || big) r.val = sat;
        else if (is32)    r.val = {32'h0, sval[31:0]};                  // see [RULE_12]
        else              r.val = sval;
        r.inc  = inc & !big & !r.inv;
        r.inex = (g | st) & !big & !r.inv;
        return r;
    endfunction : f_convert

    // Recomputes the invalid and enabled summaries from the individual bits
    function automatic logic [31:0] f_summary(input logic [31:0] s);
        logic [31:0] r;
        r = s;
        r[VX_BIT]  = |(s & INV_MASK);
        r[FEX_BIT] = (r[VX_BIT] & s[VE_BIT]) | (s[OX_BIT] & s[OE_BIT]) |
                     (s[UX_BIT] & s[UE_BIT]) | (s[ZX_BIT] & s[ZE_BIT]) |
                     (s[XX_BIT] & s[XE_BIT]);
        return r;
    endfunction : f_summary

    //************************************************
    // State
    //************************************************
    logic [31:0] fp_status_control_reg_q, fp_status_control_reg_d;
    fci_wb_t     wb_q, wb_d;
    fci_cr_t     cr_q, cr_d;
    logic        ill_q, ill_d;
    logic [3:0]  irq_sts_q, irq_sts_d;
    logic [3:0]  irq_msk_q, irq_msk_d;
    logic        irq_q, irq_d;
    logic [31:0] rdata_q, rdata_d;

    //************************************************
    // Execution
    //************************************************
    fci_op_t     op;
    logic [3:0]  cmp_cc;
    fci_cvt_t    cvt;
    logic        cvt_is32;
    logic [1:0]  cvt_rn;
    logic [3:0]  ev;
    logic [31:0] upd;

    // Decodes the issued instruction and evaluates both datapaths
    always_comb begin
        op       = i_issue.valid ? f_decode(i_issue.instr) : OP_NONE;
        cmp_cc   = f_compare(i_issue.src_a, i_issue.src_b);                // see [RULE_01]
        cvt_is32 = (op == OP_CVT_W) || (op == OP_CVT_WZ);
        cvt_rn   = ((op == OP_CVT_DZ) || (op == OP_CVT_WZ)) ? RN_ZERO      // see [RULE_07]
                                                            : fp_status_control_reg_q[RN_HI:RN_LO]; // see [RULE_06]
        cvt      = f_convert(i_issue.src_b, cvt_rn, cvt_is32);
    end

    // Next status, results, condition write, bus and interrupt state
    always_comb begin
        fp_status_control_reg_d   = fp_status_control_reg_q;
        wb_d      = '0;
        cr_d      = '0;
        ill_d     = 1'b0;
        ev        = 4'h0;
        upd       = fp_status_control_reg_q;
        irq_msk_d = irq_msk_q;
        rdata_d   = 32'h0;
        if (i_bus.wr && i_bus.addr == ADDR_FP_STATUS_CONTROL_REG) fp_status_control_reg_d = f_summary(i_bus.wdata);
        if (i_bus.wr && i_bus.addr == ADDR_IRQ_MSK) irq_msk_d = i_bus.wdata[3:0];
        unique case (op)
            OP_CMPU: begin
                upd[CC_HI:CC_LO] = cmp_cc;                                   // see [RULE_05]
                if (f_is_snan(i_issue.src_a) || f_is_snan(i_issue.src_b)) begin
                    upd[SNAN_BIT] = 1'b1;                                    // see [RULE_04]
                    ev[IRQ_SNAN]  = 1'b1;
                end
                fp_status_control_reg_d  = f_summary(upd);
                cr_d.we    = 1'b1;
                cr_d.field = i_issue.instr[25:23];                           // see [RULE_02]
                cr_d.value = cmp_cc;
            end
            OP_CVT_D, OP_CVT_DZ, OP_CVT_W, OP_CVT_WZ: begin
                upd[FR_BIT]  = cvt.inc;                                      // see [RULE_09]
                upd[FI_BIT]  = cvt.inex;                                     // see [RULE_15]
                upd[XX_BIT]  = fp_status_control_reg_q[XX_BIT] | cvt.inex;
                upd[CVI_BIT] = fp_status_control_reg_q[CVI_BIT] | cvt.inv;                   // see [RULE_16]
                upd[SNAN_BIT] = fp_status_control_reg_q[SNAN_BIT] | cvt.snan;
                upd = f_summary(upd);
                upd[FX_BIT] = fp_status_control_reg_q[FX_BIT] | (|(upd & ~fp_status_control_reg_q & (INV_MASK |
                              (32'h1 << XX_BIT))));
                fp_status_control_reg_d = upd;
                ev[IRQ_SNAN]    = cvt.snan;
                ev[IRQ_CVI]     = cvt.inv;
                ev[IRQ_INEXACT] = cvt.inex;
                wb_d.valid    = 1'b1;
                wb_d.dest_reg = i_issue.instr[25:21];
                wb_d.data     = cvt.val;                                     // see [RULE_13]
                if (i_issue.instr[0]) begin                                  // see [RULE_11]
                    cr_d.we    = 1'b1;
                    cr_d.field = CR_FIELD_1;
                    cr_d.value = {upd[FX_BIT], upd[FEX_BIT], upd[VX_BIT], upd[OX_BIT]};
                end
            end
            OP_ILLEGAL: begin
                ill_d            = 1'b1;                                     // see [RULE_10]
                ev[IRQ_ILLEGAL]  = 1'b1;
            end
            default: ;
        endcase
        // Read answers next cycle; a read of the interrupt status clears it, new events win
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                ADDR_FP_STATUS_CONTROL_REG:   rdata_d = fp_status_control_reg_q;
                ADDR_IRQ_STS: rdata_d = {28'h0, irq_sts_q};
                ADDR_IRQ_MSK: rdata_d = {28'h0, irq_msk_q};
                default:      rdata_d = 32'h0;
            endcase
        end
        irq_sts_d = ((i_bus.rd && i_bus.addr == ADDR_IRQ_STS) ? 4'h0 : irq_sts_q) | ev;
        irq_d     = |(irq_sts_d & irq_msk_d);
    end

    // Registers all state
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fp_status_control_reg_q   <= FP_STATUS_CONTROL_REG_RST;
            wb_q      <= '0;
            cr_q      <= '0;
            ill_q     <= 1'b0;
            irq_sts_q <= 4'h0;
            irq_msk_q <= 4'h0;
            irq_q     <= 1'b0;
            rdata_q   <= 32'h0;
        end else begin
            fp_status_control_reg_q   <= fp_status_control_reg_d;
            wb_q      <= wb_d;
            cr_q      <= cr_d;
            ill_q     <= ill_d;
            irq_sts_q <= irq_sts_d;
            irq_msk_q <= irq_msk_d;
            irq_q     <= irq_d;
            rdata_q   <= rdata_d;
        end
    end

    // Outputs straight from flip-flops
    assign o_wb      = wb_q;
    assign o_cr      = cr_q;
    assign o_illegal = ill_q;
    assign o_rdata   = rdata_q;
    assign o_irq     = irq_q;

    //************************************************
    // Assertions
    //************************************************
    property p_cmp_field;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        op == OP_CMPU |=> o_cr.we && o_cr.field == $past(i_issue.instr[25:23]) &&
                          fp_status_control_reg_q[CC_HI:CC_LO] == o_cr.value;
    endproperty
    a_cmp_field: assert property (p_cmp_field) else $error("compare field wrong"); // see [RULE_02]

    property p_cmp_unord;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        op == OP_CMPU && (f_is_nan(i_issue.src_a) || f_is_nan(i_issue.src_b))
            |=> o_cr.value == CC_UN;
    endproperty
    a_cmp_unord: assert property (p_cmp_unord) else $error("NaN not unordered"); // see [RULE_03]

    property p_cmp_snan;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        op == OP_CMPU && f_is_snan(i_issue.src_b) |=> fp_status_control_reg_q[SNAN_BIT] && irq_sts_q[IRQ_SNAN];
    endproperty
    a_cmp_snan: assert property (p_cmp_snan) else $error("snan bit not set"); // see [RULE_04]

    property p_cmp_only;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        op == OP_CMPU |=> $stable(fp_status_control_reg_q[FR_BIT]) && $stable(fp_status_control_reg_q[FI_BIT]) &&
                          $stable(fp_status_control_reg_q[CVI_BIT]) && !o_wb.valid;
    endproperty
    a_cmp_only: assert property (p_cmp_only) else $error("compare touched other bits"); // see [RULE_05]

    property p_cvt_trunc;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        op == OP_CVT_DZ && i_issue.src_b == 64'h3FF8_0000_0000_0000
            |=> o_wb.valid && o_wb.data == 64'h1 && fp_status_control_reg_q[FI_BIT] && !fp_status_control_reg_q[FR_BIT];
    endproperty
    a_cvt_trunc: assert property (p_cvt_trunc) else $error("1.5 not truncated"); // see [RULE_07]

    property p_sat_d;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        op == OP_CVT_D && i_issue.src_b[62:52] > EXP_BIG && !f_is_nan(i_issue.src_b)
            |=> o_wb.data == ($past(i_issue.src_b[63]) ? SAT_D_NEG : SAT_D_POS) &&
                fp_status_control_reg_q[CVI_BIT];
    endproperty
    a_sat_d: assert property (p_sat_d) else $error("64-bit saturation wrong"); // see [RULE_08]

    property p_illegal;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        i_issue.valid && !IMPL_64 && i_issue.instr[31:26] == PRIM_OPC &&
        i_issue.instr[10:1] == XO_CVT_D |=> o_illegal && !o_wb.valid ##1 !o_illegal;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal not raised"); // see [RULE_10]

    property p_record;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        (op == OP_CVT_W || op == OP_CVT_D) |=> o_cr.we == $past(i_issue.instr[0]) &&
            (!o_cr.we || o_cr.value == {fp_status_control_reg_q[FX_BIT], fp_status_control_reg_q[FEX_BIT],
                                        fp_status_control_reg_q[VX_BIT], fp_status_control_reg_q[OX_BIT]});
    endproperty
    a_record: assert property (p_record) else $error("record field wrong"); // see [RULE_11]

    property p_sat_w;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        op == OP_CVT_WZ && f_is_nan(i_issue.src_b)
            |=> o_wb.data[31:0] == SAT_W_NEG && fp_status_control_reg_q[CVI_BIT] && fp_status_control_reg_q[VX_BIT];
    endproperty
    a_sat_w: assert property (p_sat_w) else $error("32-bit NaN result wrong"); // see [RULE_14]

    property p_irq;
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        o_irq |-> $past(|(irq_sts_d & irq_msk_d));
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
endmodule : fci_unit

//--- logic/fci_pkg.sv
//----------------------------------------------------------------------------
// Contract
// [RULE_01] Opcode 63 with extended code 0 is the unordered compare of src A against src B.
// [RULE_02] Compare bits 6-8 pick the condition field that receives the four compare-code bits.
// [RULE_03] A quiet or signaling NaN operand makes the compare code read unordered.
// [RULE_04] A signaling NaN operand of the compare sets the signaling-NaN invalid bit.
// [RULE_05] The compare touches only the four compare-code bits and the signaling-NaN bit; the code also recomputes the invalid and enabled summaries.
// [RULE_06] Extended code 814 converts to a 64-bit signed integer under the rounding control.
// [RULE_07] Extended code 815 converts to a 64-bit signed integer rounding toward zero.
// [RULE_08] 64-bit conversions saturate to 0x7FFF...FFFF above range and 0x8000...0000 below.
// [RULE_09] 64-bit conversions set the incremented bit and the inexact bit; result class is left.
// [RULE_10] A 32-bit implementation treats the 64-bit conversions as illegal instructions.
// [RULE_11] Record bit 1 copies summary, enabled summary, invalid summary, overflow into field 1.
// [RULE_12] Extended code 14 converts to 32 bits under the rounding control into the low word.
// [RULE_13] Extended code 15 converts to 32 bits toward zero into the low word.
// [RULE_14] 32-bit conversions saturate the low word to 0x7FFFFFFF and 0x80000000.
// [RULE_15] After 32-bit conversions class, inexact and compare bits may hold any value.
// [RULE_16] A NaN or out-of-range conversion operand sets the invalid-convert bit.
//----------------------------------------------------------------------------
// Holds constants and carrier types of the compare and convert unit.
// Assumes instruction bit 0 is the word's most significant bit.
//----------------------------------------------------------------------------
package fci_pkg;
    //************************************************
    // Instruction encoding
    //************************************************
    localparam logic [5:0]  PRIM_OPC   = 6'h3F;   // Primary opcode 63
    localparam logic [9:0]  XO_CMPU    = 10'h000;
    localparam logic [9:0]  XO_CVT_D   = 10'h32E; // 814
    localparam logic [9:0]  XO_CVT_DZ  = 10'h32F; // 815
    localparam logic [9:0]  XO_CVT_W   = 10'h00E; // 14
    localparam logic [9:0]  XO_CVT_WZ  = 10'h00F; // 15
    localparam logic [2:0]  CR_FIELD_1 = 3'h1;
    //************************************************
    // Status register fields (bit index, LSB = 0)
    //************************************************
    localparam int FX_BIT = 31, FEX_BIT = 30, VX_BIT = 29, OX_BIT = 28, UX_BIT = 27;
    localparam int ZX_BIT = 26, XX_BIT = 25, SNAN_BIT = 24, FR_BIT = 18, FI_BIT = 17;
    localparam int CC_HI = 15, CC_LO = 12, CVI_BIT = 8, VE_BIT = 7, OE_BIT = 6;
    localparam int UE_BIT = 5, ZE_BIT = 4, XE_BIT = 3, RN_HI = 1, RN_LO = 0;
    localparam logic [31:0] INV_MASK   = 32'h01F8_0700; // All invalid-operation bits
    localparam logic [31:0] FP_STATUS_CONTROL_REG_RST  = 32'h0000_0000;
    //************************************************
    // Compare codes {less, greater, equal, unordered}
    //************************************************
    localparam logic [3:0] CC_LT = 4'h8, CC_GT = 4'h4, CC_EQ = 4'h2, CC_UN = 4'h1;
    //************************************************
    // Rounding control and conversion limits
    //************************************************
    localparam logic [1:0]  RN_NEAR = 2'h0, RN_ZERO = 2'h1, RN_PINF = 2'h2, RN_MINF = 2'h3;
    localparam logic [10:0] EXP_HALF  = 11'h3FE;  // Exponent of 0.5
    localparam logic [10:0] EXP_BIG   = 11'h43E;  // Exponent of 2**63
    localparam logic [10:0] EXP_SHIFT = 11'h3F3;  // Aligns the binary point at bit 64
    localparam logic [10:0] EXP_MAX   = 11'h7FF;
    localparam logic [64:0] LIM_D_POS = 65'h0_7FFF_FFFF_FFFF_FFFF;
    localparam logic [64:0] LIM_D_NEG = 65'h0_8000_0000_0000_0000;
    localparam logic [64:0] LIM_W_POS = 65'h0_0000_0000_7FFF_FFFF;
    localparam logic [64:0] LIM_W_NEG = 65'h0_0000_0000_8000_0000;
    localparam logic [63:0] SAT_D_POS = 64'h7FFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] SAT_D_NEG = 64'h8000_0000_0000_0000;
    localparam logic [31:0] SAT_W_POS = 32'h7FFF_FFFF;
    localparam logic [31:0] SAT_W_NEG = 32'h8000_0000;
    //************************************************
    // Register map and interrupt causes
    //************************************************
    localparam logic [7:0] ADDR_FP_STATUS_CONTROL_REG   = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h08;
    localparam int IRQ_SNAN = 0, IRQ_CVI = 1, IRQ_INEXACT = 2, IRQ_ILLEGAL = 3;
    //************************************************
    // Types
    //************************************************
    typedef enum logic [2:0] {
        OP_NONE, OP_CMPU, OP_CVT_D, OP_CVT_DZ, OP_CVT_W, OP_CVT_WZ, OP_ILLEGAL
    } fci_op_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [63:0] src_a;
        logic [63:0] src_b;
    } fci_issue_t;
    typedef struct packed {
        logic        valid;
        logic [4:0]  dest_reg;
        logic [63:0] data;
    } fci_wb_t;
    typedef struct packed {
        logic       we;
        logic [2:0] field;
        logic [3:0] value;
    } fci_cr_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } fci_bus_t;
    typedef struct packed {
        logic [63:0] val;
        logic        inc;
        logic        inex;
        logic        inv;
        logic        snan;
    } fci_cvt_t;
endpackage : fci_pkg

//--- bench/fci_issue_model.sv
// Issue stage model: hands the unit one instruction with its operands per request.
// Assumes requests are driven just after a rising clock edge.
`timescale 1ns/1ps
module fci_issue_model (
    // Clock and reset
    input  wire logic                i_sys_clk,
    input  wire logic                i_rst_b,
    // Request from the bench
    input  wire logic                i_req,
    input  wire logic [31:0]         i_instr,
    input  wire logic [63:0]         i_a,
    input  wire logic [63:0]         i_b,
    // Issue to the unit
    output      fci_pkg::fci_issue_t o_issue
);
    import fci_pkg::*;
    logic [63:0] last_a_q;
    logic [63:0] last_b_q;
    // Keep the last operands so that idle cycles never repeat them
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_a_q <= 64'h0;
            last_b_q <= 64'h0;
        end else if (i_req) begin
            last_a_q <= i_a;
            last_b_q <= i_b;
        end
    end
    // Outside an issue slot the buses show the inverse of the last value
    always_comb begin
        o_issue = '{i_req, i_instr, i_a, i_b};
        if (!i_req) o_issue = '{1'b0, ~i_instr, ~last_a_q, ~last_b_q};
    end
endmodule : fci_issue_model

//--- bench/fci_unit_test.sv
// Testbench of the compare and convert unit: instruction and register sequences.
// Assumes the design package and the issue model are compiled first.
`timescale 1ns/1ps
module fci_unit_test;
    import fci_pkg::*;
    logic clk, rst_b, req, irq, ill, ill32;
    logic [31:0] instr, rdata, rd;
    logic [63:0] a, b;
    fci_issue_t iss;
    fci_bus_t   bus;
    fci_wb_t    wb;
    fci_cr_t    cr;
    int error_cnt = 0;
    int n_checks = 0;
    fci_issue_model fci_issue_model_i (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req(req),
        .i_instr(instr), .i_a(a), .i_b(b), .o_issue(iss));
    fci_unit fci_unit_i (.i_sys_clk(clk), .i_rst_b(rst_b), .i_issue(iss), .o_wb(wb), .o_cr(cr),
        .o_illegal(ill), .i_bus(bus), .o_rdata(rdata), .o_irq(irq));
    // Narrow implementation sees the same traffic
    fci_unit #(.IMPL_64(1'b0)) fci_unit_i32 (.i_sys_clk(clk), .i_rst_b(rst_b), .i_issue(iss),
        .o_wb(), .o_cr(), .o_illegal(ill32), .i_bus(bus), .o_rdata(), .o_irq());
    // Clock of 10 ns
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    //****************************************
    // Tasks
    //****************************************
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic op(input logic [4:0] t, input logic [9:0] xo, input logic rc,
                      input logic [63:0] va, input logic [63:0] vb);
        @(posedge clk);
        req <= 1'b1;
        instr <= {PRIM_OPC, t, 10'h000, xo, rc};
        a <= va;
        b <= vb;
        @(posedge clk);
        req <= 1'b0;
        #1;
    endtask : op
    task automatic bw(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        bus <= '{1'b1, 1'b0, ad, d};
        @(posedge clk);
        bus <= '0;
    endtask : bw
    task automatic br(input logic [7:0] ad);
        @(posedge clk);
        bus <= '{1'b0, 1'b1, ad, 32'h0};
        @(posedge clk);
        bus <= '0;
        #1 rd = rdata;
    endtask : br
    task automatic cvt(input logic [9:0] xo, input logic [1:0] rn, input logic [63:0] v,
                       input logic [63:0] r, input logic [2:0] m, input logic [2:0] f);
        bw(ADDR_FP_STATUS_CONTROL_REG, {30'h0, rn});
        op(5'h05, xo, 1'b0, 64'h0, v);
        chk("wb_data", r, wb.data);
        chk("wb_dest", {1'b1, 5'h05}, {wb.valid, wb.dest_reg});
        chk("cr_we", 64'h0, cr.we);
        br(ADDR_FP_STATUS_CONTROL_REG);
        chk("flags", f, m & {rd[FR_BIT], rd[FI_BIT], rd[CVI_BIT]});
    endtask : cvt
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    // Watchdog against a hang
    initial begin
        #50000;
        error_cnt++;
        complete_run();
    end
    //****************************************
    // Test sequence
    //****************************************
    initial begin
        rst_b = 1'b0;
        req = 1'b0;
        instr = 32'h0;
        a = 64'h0;
        b = 64'h0;
        bus = '0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        bw(ADDR_IRQ_MSK, 32'h0000_0001);
        op(5'h18, XO_CMPU, 1'b0, 64'h3FF0_0000_0000_0000, 64'h4000_0000_0000_0000);
        chk("cr", {1'b1, 3'h6, CC_LT}, cr);
        op(5'h1C, XO_CMPU, 1'b0, 64'h4000_0000_0000_0000, 64'h3FF0_0000_0000_0000);
        chk("cr", {1'b1, 3'h7, CC_GT}, cr);
        op(5'h00, XO_CMPU, 1'b0, 64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000);
        chk("cr", {1'b1, 3'h0, CC_EQ}, cr);
        op(5'h04, XO_CMPU, 1'b1, 64'h7FF8_0000_0000_0000, 64'h3FF0_0000_0000_0000);
        chk("cr", {1'b1, 3'h1, CC_UN}, cr);
        br(ADDR_FP_STATUS_CONTROL_REG);
        chk("status", 32'h0000_1000, rd);
        op(5'h04, XO_CMPU, 1'b0, 64'h3FF0_0000_0000_0000, 64'h7FF0_0000_0000_0001);
        chk("cr", {1'b1, 3'h1, CC_UN}, cr);
        br(ADDR_FP_STATUS_CONTROL_REG);
        chk("status", 32'h2100_1000, rd);
        chk("irq", 64'h1, irq);
        br(ADDR_IRQ_STS);
        chk("irq_sts", 32'h0000_0001, rd);
        @(posedge clk);
        #1 chk("irq", 64'h0, irq);
        br(8'h0C);
        chk("unmapped", 64'h0, rd);
        $display("test compare done");
        cvt(XO_CVT_D, RN_NEAR, 64'h4004_0000_0000_0000, 64'h2, 3'h7, 3'h2);
        cvt(XO_CVT_D, RN_PINF, 64'h4004_0000_0000_0000, 64'h3, 3'h7, 3'h6);
        cvt(XO_CVT_DZ, RN_PINF, 64'h4004_0000_0000_0000, 64'h2, 3'h7, 3'h2);
        cvt(XO_CVT_D, RN_MINF, 64'hC004_0000_0000_0000, -64'sd3, 3'h3, 3'h2);
        cvt(XO_CVT_D, RN_NEAR, 64'h43F0_0000_0000_0000, SAT_D_POS, 3'h1, 3'h1);
        cvt(XO_CVT_DZ, RN_NEAR, 64'hC3F0_0000_0000_0000, SAT_D_NEG, 3'h1, 3'h1);
        cvt(XO_CVT_W, RN_PINF, 64'h4004_0000_0000_0000, 64'h3, 3'h5, 3'h4);
        cvt(XO_CVT_WZ, RN_PINF, 64'hC004_0000_0000_0000, 64'hFFFF_FFFE, 3'h5, 3'h0);
        cvt(XO_CVT_W, RN_NEAR, 64'h41F0_0000_0000_0000, SAT_W_POS, 3'h1, 3'h1);
        cvt(XO_CVT_WZ, RN_NEAR, 64'hC1F0_0000_0000_0000, SAT_W_NEG, 3'h1, 3'h1);
        chk("irq", 64'h0, irq);
        bw(ADDR_FP_STATUS_CONTROL_REG, 32'h0);
        op(5'h05, XO_CVT_D, 1'b1, 64'h0, 64'h43F0_0000_0000_0000);
        chk("cr", {1'b1, CR_FIELD_1, 4'hA}, cr);
        $display("test convert done");
        op(5'h05, XO_CVT_D, 1'b0, 64'h0, 64'h4004_0000_0000_0000);
        chk("illegal", 2'b10, {ill32, ill});
        op(5'h05, 10'h3FF, 1'b0, 64'h0, 64'h0);
        chk("illegal", 2'b11, {ill32, ill});
        $display("test illegal done");
        complete_run();
    end
endmodule : fci_unit_test
